// [rmr_relay_io.sv]
// four-channel remote mode input and relay output block with configuration registers
`timescale 1ns/1ps
module rmr_relay_io #(
  parameter int NCH = rmr_pkg::NCH,
  parameter int DEB_CYC = rmr_pkg::DEB_CYC,
  parameter bit WARN_EN = 1'b1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // register port
  input wire logic [rmr_pkg::ADDR_W-1:0] addr_i,
  input wire logic [rmr_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [rmr_pkg::DATA_W-1:0] rdata_o,
  // contact inputs, high when the pair is closed
  input wire logic [NCH-1:0] contact_i,
  // plant condition inputs from the controller
  input wire logic [rmr_pkg::MODE_W-1:0] local_mode_i,
  input wire logic local_mode_set_i,
  input wire logic alarm_stop_i,
  input wire logic cavity_alarm_i,
  input wire logic any_alarm_i,
  input wire logic hot_runner_alarm_i,
  input wire logic temp_limit_alarm_i,
  input wire logic pressure_alarm_i,
  input wire logic fatal_error_i,
  input wire logic warn_i,
  input wire logic flow_alarm_i,
  // controller state outputs
  output logic [rmr_pkg::MODE_W-1:0] mode_o,
  output logic mold_protect_o,
  output logic user_auth_o,
  // relay coils, high drives moving contact to normally-open
  output logic [NCH-1:0] relay_o
);
  localparam int SW = rmr_pkg::SEL_W;

  // per-channel function fields, software written
  logic [NCH*SW-1:0] in_cfg;
  logic [NCH*SW-1:0] out_cfg;
  logic [NCH-1:0] level;
  logic [NCH-1:0] level_q;
  logic [rmr_pkg::MODE_W-1:0] mode;
  logic auto_stopped;
  logic mold_prot;
  logic started;

  function automatic logic [SW-1:0] field(input logic [NCH*SW-1:0] cfg, input int ch);
    field = cfg[ch*SW +: SW];
  endfunction : field

  function automatic logic out_func(input logic [SW-1:0] sel, input logic [4:0] st,
                                    input logic [8:0] al);
    case (sel)
      rmr_pkg::OUT_BOOST: out_func = st[0];
      rmr_pkg::OUT_CAVITY: out_func = al[0];
      rmr_pkg::OUT_CTRL_ALM: out_func = al[1];
      rmr_pkg::OUT_HOT_RUNNER: out_func = al[2];
      rmr_pkg::OUT_INJ_INHIBIT: out_func = st[1];
      rmr_pkg::OUT_INJ_INHIBIT_EXT: out_func = st[1];
      rmr_pkg::OUT_PRESSURE: out_func = al[3];
      rmr_pkg::OUT_STOPPED: out_func = st[2];
      rmr_pkg::OUT_TEMP_DIST: out_func = al[4];
      rmr_pkg::OUT_WARN: out_func = al[5];
      rmr_pkg::OUT_WATER_FLOW: out_func = al[6];
      default: out_func = 1'b0;
    endcase
  endfunction : out_func

  // input conditioning and per-channel decode
  logic [NCH-1:0] rise;
  logic [NCH-1:0] is_mok;
  logic [NCH-1:0] is_key;
  logic [rmr_pkg::CMD_W-1:0] cmd_ch [NCH];
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_in
      rmr_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .raw_i(contact_i[g]),
        .level_o(level[g])
      );
      assign rise[g] = level[g] && !level_q[g];
      // unused selection decodes to nothing
      assign is_mok[g] = field(in_cfg, g) == rmr_pkg::IN_MACH_OK;
      assign is_key[g] = field(in_cfg, g) == rmr_pkg::IN_PASSKEY;
      assign cmd_ch[g][rmr_pkg::CMD_BOOST] = rise[g] && field(in_cfg, g) == rmr_pkg::IN_BOOST;
      assign cmd_ch[g][rmr_pkg::CMD_RUN] = rise[g] && field(in_cfg, g) == rmr_pkg::IN_RUN;
      assign cmd_ch[g][rmr_pkg::CMD_SHUTDOWN] = rise[g] && field(in_cfg, g) == rmr_pkg::IN_SHUTDOWN;
      assign cmd_ch[g][rmr_pkg::CMD_STANDBY] = rise[g] && field(in_cfg, g) == rmr_pkg::IN_STANDBY;
      assign cmd_ch[g][rmr_pkg::CMD_STARTUP] = rise[g] && field(in_cfg, g) == rmr_pkg::IN_STARTUP;
      assign cmd_ch[g][rmr_pkg::CMD_STOP] = rise[g] && field(in_cfg, g) == rmr_pkg::IN_STOP;
    end
  endgenerate

  // gather across channels
  logic [rmr_pkg::CMD_W-1:0] cmd;
  logic any_mok;
  logic mok_closed;
  logic mok_fall;
  logic key_closed;
  always_comb begin
    cmd = '0;
    any_mok = 1'b0;
    mok_closed = 1'b1;
    mok_fall = 1'b0;
    key_closed = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      cmd = cmd | cmd_ch[i];
      if (is_mok[i]) begin
        any_mok = 1'b1;
        mok_closed = mok_closed & level[i];
        mok_fall = mok_fall | (level_q[i] && !level[i]);
      end
      key_closed = key_closed | (is_key[i] & level[i]);
    end
  end

  // run and startup only permitted while every machine-ready input is closed
  wire run_ok = !any_mok || mok_closed;
  wire want_run = cmd[rmr_pkg::CMD_RUN] || (local_mode_set_i && local_mode_i == rmr_pkg::MODE_RUN);
  wire want_start = cmd[rmr_pkg::CMD_STARTUP] || (local_mode_set_i && local_mode_i == rmr_pkg::MODE_STARTUP);
  wire force_stop = mok_fall || alarm_stop_i;

  // mode selection, remote or forced stop has priority, then run, then startup; local stop, standby, shutdown or boost requests lose to any remote command
  logic [rmr_pkg::MODE_W-1:0] next_mode;
  always_comb begin
    next_mode = mode;
    if (local_mode_set_i && local_mode_i != rmr_pkg::MODE_RUN && local_mode_i != rmr_pkg::MODE_STARTUP) begin
      next_mode = local_mode_i;
    end
    if (cmd[rmr_pkg::CMD_BOOST]) begin
      next_mode = rmr_pkg::MODE_BOOST;
    end
    if (cmd[rmr_pkg::CMD_STANDBY]) begin
      next_mode = rmr_pkg::MODE_STANDBY;
    end
    if (cmd[rmr_pkg::CMD_SHUTDOWN]) begin
      next_mode = rmr_pkg::MODE_SHUTDOWN;
    end
    if (want_start && run_ok) begin
      next_mode = rmr_pkg::MODE_STARTUP;
    end
    if (want_run && run_ok) begin
      next_mode = rmr_pkg::MODE_RUN;
    end
    if (cmd[rmr_pkg::CMD_STOP] || force_stop) begin
      next_mode = rmr_pkg::MODE_STOP;
    end
  end

  // stopped flag: set only by an alarm-driven stop, cleared on leaving stop
  wire manual_stop = cmd[rmr_pkg::CMD_STOP] || (local_mode_set_i && local_mode_i == rmr_pkg::MODE_STOP);
  wire next_auto_stopped = alarm_stop_i ? 1'b1 :
                           (manual_stop || next_mode != rmr_pkg::MODE_STOP) ? 1'b0 : auto_stopped;
  wire next_mold_prot = mok_fall ? 1'b1 : (next_mode != rmr_pkg::MODE_STOP) ? 1'b0 : mold_prot;
  // idle until run has been reached; back to idle when stop or shutdown
  wire next_started = (next_mode == rmr_pkg::MODE_RUN) ? 1'b1 :
                      (next_mode == rmr_pkg::MODE_STOP || next_mode == rmr_pkg::MODE_SHUTDOWN) ? 1'b0 : started;

  // output function sources
  wire inj_inhibit = !started || temp_limit_alarm_i;
  wire [4:0] st_vec = {2'b00, auto_stopped, inj_inhibit, mode == rmr_pkg::MODE_BOOST};
  wire [8:0] al_vec = {2'b00, flow_alarm_i, warn_i & WARN_EN, fatal_error_i, pressure_alarm_i,
                       hot_runner_alarm_i, any_alarm_i, cavity_alarm_i};
  logic [NCH-1:0] next_relay;
  generate
    for (g = 0; g < NCH; g++) begin : g_out
      assign next_relay[g] = out_func(field(out_cfg, g), st_vec, al_vec);
    end
  endgenerate

  // register decode
  wire wr_in = wr_i && addr_i == rmr_pkg::OFS_IN_CFG;
  wire wr_out = wr_i && addr_i == rmr_pkg::OFS_OUT_CFG;
  logic [rmr_pkg::DATA_W-1:0] stat_word;
  logic [rmr_pkg::DATA_W-1:0] io_word;
  logic [rmr_pkg::DATA_W-1:0] rd_mux;
  always_comb begin
    stat_word = '0;
    stat_word[rmr_pkg::ST_MODE_LSB +: rmr_pkg::MODE_W] = mode;
    stat_word[rmr_pkg::ST_MOLD_PROT] = mold_prot;
    stat_word[rmr_pkg::ST_AUTH] = user_auth_o;
    stat_word[rmr_pkg::ST_AUTO_STOP] = auto_stopped;
    stat_word[rmr_pkg::ST_MACH_OK] = run_ok;
    io_word = '0;
    io_word[rmr_pkg::IO_IN_LSB +: NCH] = level;
    io_word[rmr_pkg::IO_OUT_LSB +: NCH] = relay_o;
    case (addr_i)
      rmr_pkg::OFS_IN_CFG: rd_mux = rmr_pkg::DATA_W'(in_cfg);
      rmr_pkg::OFS_OUT_CFG: rd_mux = rmr_pkg::DATA_W'(out_cfg);
      rmr_pkg::OFS_CTRL_STAT: rd_mux = stat_word;
      rmr_pkg::OFS_IO_STAT: rd_mux = io_word;
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      in_cfg <= rmr_pkg::IN_CFG_RST;
      out_cfg <= rmr_pkg::OUT_CFG_RST;
      level_q <= '0;
      mode <= rmr_pkg::MODE_STOP;
      auto_stopped <= 1'b0;
      mold_prot <= 1'b0;
      started <= 1'b0;
      relay_o <= '0;
      mode_o <= rmr_pkg::MODE_STOP;
      mold_protect_o <= 1'b0;
      user_auth_o <= 1'b0;
      rdata_o <= '0;
    end else begin
      if (wr_in) begin
        in_cfg <= wdata_i[NCH*SW-1:0];
      end
      if (wr_out) begin
        out_cfg <= wdata_i[NCH*SW-1:0];
      end
      level_q <= level;
      mode <= next_mode;
      auto_stopped <= next_auto_stopped;
      mold_prot <= next_mold_prot;
      started <= next_started;
      relay_o <= next_relay;
      mode_o <= next_mode;
      mold_protect_o <= next_mold_prot;
      user_auth_o <= key_closed;
      rdata_o <= rd_i ? rd_mux : '0;
    end
  end
endmodule : rmr_relay_io

// [rmr_pkg.sv]
// package of constants, encodings and register map for the remote mode relay io block
package rmr_pkg;
  localparam int NCH = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;
  // clock rate and debounce time
  localparam int CLK_HZ = 125_000_000;
  localparam int DEB_US = 10_000;
  localparam int DEB_CYC = (CLK_HZ / 1_000_000) * DEB_US;
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_IN_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_OUT_CFG = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CTRL_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IO_STAT = 4'hc;
  // input functions
  localparam logic [SEL_W-1:0] IN_UNUSED = 4'h0;
  localparam logic [SEL_W-1:0] IN_BOOST = 4'h1;
  localparam logic [SEL_W-1:0] IN_MACH_OK = 4'h2;
  localparam logic [SEL_W-1:0] IN_PASSKEY = 4'h3;
  localparam logic [SEL_W-1:0] IN_RUN = 4'h4;
  localparam logic [SEL_W-1:0] IN_SHUTDOWN = 4'h5;
  localparam logic [SEL_W-1:0] IN_STANDBY = 4'h6;
  localparam logic [SEL_W-1:0] IN_STARTUP = 4'h7;
  localparam logic [SEL_W-1:0] IN_STOP = 4'h8;
  // output functions
  localparam logic [SEL_W-1:0] OUT_UNUSED = 4'h0;
  localparam logic [SEL_W-1:0] OUT_BOOST = 4'h1;
  localparam logic [SEL_W-1:0] OUT_CAVITY = 4'h2;
  localparam logic [SEL_W-1:0] OUT_CTRL_ALM = 4'h3;
  localparam logic [SEL_W-1:0] OUT_HOT_RUNNER = 4'h4;
  localparam logic [SEL_W-1:0] OUT_INJ_INHIBIT = 4'h5;
  localparam logic [SEL_W-1:0] OUT_INJ_INHIBIT_EXT = 4'h6;
  localparam logic [SEL_W-1:0] OUT_PRESSURE = 4'h7;
  localparam logic [SEL_W-1:0] OUT_STOPPED = 4'h8;
  localparam logic [SEL_W-1:0] OUT_TEMP_DIST = 4'h9;
  localparam logic [SEL_W-1:0] OUT_WARN = 4'ha;
  localparam logic [SEL_W-1:0] OUT_WATER_FLOW = 4'hb;
  // reset configuration: inputs run, standby, startup, stop; outputs inhibit, disturbance, boost, unused
  localparam logic [NCH*SEL_W-1:0] IN_CFG_RST = {IN_STOP, IN_STARTUP, IN_STANDBY, IN_RUN};
  localparam logic [NCH*SEL_W-1:0] OUT_CFG_RST = {OUT_UNUSED, OUT_BOOST, OUT_TEMP_DIST, OUT_INJ_INHIBIT};
  // mode command one-hot bit positions
  localparam int CMD_W = 6;
  localparam int CMD_BOOST = 0;
  localparam int CMD_RUN = 1;
  localparam int CMD_SHUTDOWN = 2;
  localparam int CMD_STANDBY = 3;
  localparam int CMD_STARTUP = 4;
  localparam int CMD_STOP = 5;
  // controller mode encoding
  localparam int MODE_W = 3;
  localparam logic [MODE_W-1:0] MODE_STOP = 3'h0;
  localparam logic [MODE_W-1:0] MODE_RUN = 3'h1;
  localparam logic [MODE_W-1:0] MODE_STANDBY = 3'h2;
  localparam logic [MODE_W-1:0] MODE_STARTUP = 3'h3;
  localparam logic [MODE_W-1:0] MODE_SHUTDOWN = 3'h4;
  localparam logic [MODE_W-1:0] MODE_BOOST = 3'h5;
  // status register field positions
  localparam int ST_MODE_LSB = 0;
  localparam int ST_MOLD_PROT = 4;
  localparam int ST_AUTH = 5;
  localparam int ST_AUTO_STOP = 6;
  localparam int ST_MACH_OK = 7;
  localparam int IO_IN_LSB = 0;
  localparam int IO_OUT_LSB = 4;
endpackage : rmr_pkg

// [rmr_debounce.sv]
// two-stage synchroniser plus stable-count debouncer for one contact input
`timescale 1ns/1ps
module rmr_debounce #(
  parameter int DEB_CYC = rmr_pkg::DEB_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // raw contact, high when closed
  input wire logic raw_i,
  // debounced level
  output logic level_o
);
  localparam int CW = $clog2(DEB_CYC + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(DEB_CYC);
  logic sync_a;
  logic sync_b;
  logic [CW-1:0] cnt;
  wire differs = sync_b != level_o;
  wire settled = cnt == CNT_MAX;
  wire [CW-1:0] next_cnt = differs ? cnt + CW'(1) : '0;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      cnt <= '0;
      level_o <= 1'b0;
    end else begin
      sync_a <= raw_i;
      sync_b <= sync_a;
      cnt <= settled ? '0 : next_cnt;
      if (differs && settled) begin
        level_o <= sync_b;
      end
    end
  end
endmodule : rmr_debounce

// [rmr_relay_io_assertions.sv]
// assertion checker for the remote mode relay io block
`timescale 1ns/1ps
module rmr_relay_io_assertions #(
  parameter int NCH = rmr_pkg::NCH
) (
  // clock, reset and register port
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [rmr_pkg::ADDR_W-1:0] addr_i,
  input wire logic [rmr_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [rmr_pkg::DATA_W-1:0] rdata_o,
  // conditions and state
  input wire logic any_alarm_i,
  input wire logic temp_limit_alarm_i,
  input wire logic fatal_error_i,
  input wire logic [rmr_pkg::MODE_W-1:0] mode_o,
  input wire logic mold_protect_o,
  input wire logic [NCH-1:0] relay_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // shadow of the output function fields, three deep to know when they have settled
  logic [NCH*4-1:0] ocfg, ocfg_d, ocfg_d2;
  logic [NCH-1:0] off_m, boost_m, inh_m, ctrl_m, dist_m;
  wire cfg_ok = (ocfg == ocfg_d) && (ocfg_d == ocfg_d2);
  always_ff @(posedge clk_i) begin
    if (!rstn_i) ocfg <= rmr_pkg::OUT_CFG_RST[NCH*4-1:0];
    else if (wr_i && addr_i == rmr_pkg::OFS_OUT_CFG) ocfg <= wdata_i[NCH*4-1:0];
    ocfg_d <= ocfg;
    ocfg_d2 <= ocfg_d;
  end
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      off_m[i] = ocfg[i*4 +: 4] == rmr_pkg::OUT_UNUSED;
      boost_m[i] = ocfg[i*4 +: 4] == rmr_pkg::OUT_BOOST;
      inh_m[i] = ocfg[i*4 +: 4] == rmr_pkg::OUT_INJ_INHIBIT || ocfg[i*4 +: 4] == rmr_pkg::OUT_INJ_INHIBIT_EXT;
      ctrl_m[i] = ocfg[i*4 +: 4] == rmr_pkg::OUT_CTRL_ALM;
      dist_m[i] = ocfg[i*4 +: 4] == rmr_pkg::OUT_TEMP_DIST;
    end
  end
  sequence s_run_quiet;
    (mode_o == rmr_pkg::MODE_RUN && !temp_limit_alarm_i && cfg_ok)[*3];
  endsequence
  sequence s_temp_held;
    (temp_limit_alarm_i && cfg_ok)[*3];
  endsequence
  rst_outs_a: assert property (disable iff (1'b0)
    !rstn_i |=> relay_o == '0 && mode_o == rmr_pkg::MODE_STOP && !mold_protect_o) else $error("reset state wrong");
  rd_idle_a: assert property (!rd_i |=> rdata_o == '0) else $error("read data outside read");
  unmapped_a: assert property (rd_i && addr_i[1:0] != 2'h0 |=> rdata_o == '0) else $error("unmapped read");
  stat_rd_a: assert property (
    rd_i && addr_i == rmr_pkg::OFS_CTRL_STAT |=> rdata_o[2:0] == $past(mode_o) && rdata_o[31:8] == '0)
    else $error("status read wrong");
  unused_off_a: assert property (cfg_ok |-> (relay_o & off_m) == '0) else $error("unused relay on");
  boost_out_a: assert property (
    (mode_o == rmr_pkg::MODE_BOOST && cfg_ok)[*3] |-> (relay_o & boost_m) == boost_m) else $error("boost relay off");
  inh_pair_a: assert property (cfg_ok |-> (relay_o & inh_m) == '0 || (relay_o & inh_m) == inh_m)
    else $error("inhibit relays differ");
  inh_temp_a: assert property (s_temp_held |-> (relay_o & inh_m) == inh_m) else $error("inhibit off");
  inh_run_a: assert property (s_run_quiet |-> (relay_o & inh_m) == '0) else $error("inhibit in run");
  alarm_out_a: assert property (
    (any_alarm_i && cfg_ok)[*3] |-> (relay_o & ctrl_m) == ctrl_m) else $error("alarm relay off");
  fatal_out_a: assert property (
    (fatal_error_i && cfg_ok)[*3] |-> (relay_o & dist_m) == dist_m) else $error("disturbance relay off");
  protect_stop_a: assert property ($rose(mold_protect_o) |-> mode_o == rmr_pkg::MODE_STOP)
    else $error("protect outside stop");
endmodule : rmr_relay_io_assertions

bind rmr_relay_io rmr_relay_io_assertions #(.NCH(NCH)) rmr_relay_io_assertions_i (
  .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .any_alarm_i(any_alarm_i), .temp_limit_alarm_i(temp_limit_alarm_i),
  .fatal_error_i(fatal_error_i), .mode_o(mode_o), .mold_protect_o(mold_protect_o), .relay_o(relay_o));

// [rmr_plant_model.sv]
// model of the plant equipment that closes the contact pairs, with chatter on every change
`timescale 1ns/1ps
module rmr_plant_model (
  // clock and request
  input wire logic clk_i,
  input wire logic [3:0] close_i,
  input wire logic bounce_i,
  // contact pairs, high when shorted
  output logic [3:0] contact_o
);
  logic [3:0] pair = 4'h0;
  logic [3:0] prev = 4'h0;
  logic [3:0] chg = 4'h0;
  logic [1:0] cnt = 2'h0;
  assign contact_o = pair;
  always @(posedge clk_i) begin
    prev <= close_i;
    if (bounce_i && close_i != prev) begin
      chg <= close_i ^ prev;
      cnt <= 2'h3;
    end else if (cnt != 2'h0) cnt <= cnt - 2'h1;
    // a changing pair chatters before it settles
    pair <= cnt[0] ? close_i ^ chg : close_i;
  end
endmodule : rmr_plant_model

// [tb_top.sv]
// self-checking testbench for the remote mode relay io block
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [3:0] req = 4'h0;
  logic [3:0] contact;
  logic [2:0] lmode = 3'h0;
  logic lset = 1'b0;
  logic astop = 1'b0;
  logic [7:0] cond = 8'h0;
  logic [2:0] mode_o;
  logic mold_protect_o;
  logic user_auth_o;
  logic [3:0] relay_o;
  int bad_count = 0;
  int num_checks = 0;
  // input code, mode, relays (ch0 inhibit, ch1 boost, ch2 inhibit ext)
  localparam logic [10:0] MROW [6] = '{{4'h7, 3'h3, 4'h5}, {4'h4, 3'h1, 4'h0}, {4'h1, 3'h5, 4'h2},
    {4'h6, 3'h2, 4'h0}, {4'h5, 3'h4, 4'h5}, {4'h8, 3'h0, 4'h5}};
  // output code on ch3, condition inputs, relay 3
  localparam logic [12:0] OROW [11] = '{{4'h2, 8'h01, 1'h1}, {4'h3, 8'h02, 1'h1}, {4'h4, 8'h04, 1'h1},
    {4'h7, 8'h08, 1'h1}, {4'h9, 8'h10, 1'h1}, {4'ha, 8'h20, 1'h1}, {4'hb, 8'h40, 1'h1}, {4'h5, 8'h80, 1'h1},
    {4'h6, 8'h80, 1'h1}, {4'h5, 8'h10, 1'h0}, {4'h0, 8'hff, 1'h0}};
  initial forever #4 clk_i = ~clk_i;
  rmr_relay_io #(.DEB_CYC(4)) rmr_relay_io_i (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .contact_i(contact), .local_mode_i(lmode),
    .local_mode_set_i(lset), .alarm_stop_i(astop), .cavity_alarm_i(cond[0]), .any_alarm_i(cond[1]),
    .hot_runner_alarm_i(cond[2]), .pressure_alarm_i(cond[3]), .fatal_error_i(cond[4]), .warn_i(cond[5]),
    .flow_alarm_i(cond[6]), .temp_limit_alarm_i(cond[7]), .mode_o(mode_o), .mold_protect_o(mold_protect_o),
    .user_auth_o(user_auth_o), .relay_o(relay_o));
  rmr_plant_model rmr_plant_model_i (.clk_i(clk_i), .close_i(req), .bounce_i(1'b1), .contact_o(contact));
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd
  // move one contact pair and wait for debounce and relay update
  task automatic pair(input int ch, input logic v);
    @(posedge clk_i);
    req[ch] <= v;
    repeat (24) @(posedge clk_i);
    #1;
  endtask : pair
  task automatic pulse_local(input logic [2:0] m);
    @(posedge clk_i);
    lmode <= m;
    lset <= 1'b1;
    @(posedge clk_i);
    lset <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask : pulse_local
  // watchdog far beyond the roughly 860 cycles the tests take
  initial begin
    #100_000;
    bad_count++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1 chk(relay_o, 32'h0);
    chk(mode_o, rmr_pkg::MODE_STOP);
    repeat (3) @(posedge clk_i);
    #1 chk(relay_o, 32'h1);
    rd(rmr_pkg::OFS_IN_CFG, 32'h8764);
    rd(rmr_pkg::OFS_OUT_CFG, 32'h195);
    rd(rmr_pkg::OFS_IO_STAT, 32'h10);
    wr(4'h2, 32'hffff);
    rd(4'h2, 32'h0);
    $display("test reset done");
    wr(rmr_pkg::OFS_OUT_CFG, 32'h615);
    for (int i = 0; i < 6; i++) begin
      wr(rmr_pkg::OFS_IN_CFG, {28'h0, MROW[i][10:7]});
      pair(0, 1'b1);
      chk(mode_o, MROW[i][6:4]);
      chk(relay_o, MROW[i][3:0]);
      pair(0, 1'b0);
      chk(mode_o, MROW[i][6:4]);
    end
    $display("test mode commands done");
    wr(rmr_pkg::OFS_IN_CFG, 32'h324);
    pair(0, 1'b1);
    chk(mode_o, rmr_pkg::MODE_STOP);
    pair(0, 1'b0);
    pair(1, 1'b1);
    pair(0, 1'b1);
    chk(mode_o, rmr_pkg::MODE_RUN);
    rd(rmr_pkg::OFS_CTRL_STAT, 32'h81);
    pair(0, 1'b0);
    pair(3, 1'b1);
    chk(mode_o, rmr_pkg::MODE_RUN);
    pair(2, 1'b1);
    chk(user_auth_o, 32'h1);
    pair(2, 1'b0);
    chk(user_auth_o, 32'h0);
    pair(1, 1'b0);
    chk(mode_o, rmr_pkg::MODE_STOP);
    chk(mold_protect_o, 32'h1);
    rd(rmr_pkg::OFS_IO_STAT, 32'h58);
    pair(3, 1'b0);
    pair(1, 1'b1);
    pair(0, 1'b1);
    chk(mode_o, rmr_pkg::MODE_RUN);
    chk(mold_protect_o, 32'h0);
    pair(0, 1'b0);
    $display("test machine ready done");
    for (int i = 0; i < 11; i++) begin
      wr(rmr_pkg::OFS_OUT_CFG, {16'h0, OROW[i][12:9], 12'h0});
      @(posedge clk_i);
      cond <= OROW[i][8:1];
      repeat (4) @(posedge clk_i);
      #1 chk(relay_o[3], OROW[i][0]);
      @(posedge clk_i);
      cond <= 8'h0;
      repeat (4) @(posedge clk_i);
      #1 chk(relay_o[3], 32'h0);
    end
    $display("test output functions done");
    wr(rmr_pkg::OFS_OUT_CFG, 32'h8000);
    @(posedge clk_i);
    astop <= 1'b1;
    @(posedge clk_i);
    astop <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1 chk(mode_o, rmr_pkg::MODE_STOP);
    chk(relay_o, 32'h8);
    pulse_local(rmr_pkg::MODE_RUN);
    chk(relay_o, 32'h0);
    wr(rmr_pkg::OFS_OUT_CFG, 32'h1000);
    pulse_local(rmr_pkg::MODE_BOOST);
    chk(relay_o, 32'h8);
    wr(rmr_pkg::OFS_OUT_CFG, 32'h8000);
    pulse_local(rmr_pkg::MODE_STOP);
    chk(mode_o, rmr_pkg::MODE_STOP);
    chk(relay_o, 32'h0);
    $display("test stopped output done");
    // open machine-ready so nothing is held closed across the reset
    pair(1, 1'b0);
    chk(mold_protect_o, 32'h1);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1 chk(mold_protect_o, 32'h0);
    chk(relay_o, 32'h0);
    rd(rmr_pkg::OFS_OUT_CFG, 32'h195);
    chk(relay_o, 32'h1);
    $display("test mid-run reset done");
    test_done();
  end
endmodule : tb_top
